// file: pwu_pkg.sv
// Package for the six-channel pulse width unit: register map, fields, counts and types.
// Assumes a single 100 MHz system clock and an 8-bit register port.
package pwu_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] ADDR_DUTY0 = 5'h00;
  localparam logic [4:0] ADDR_PRE0 = 5'h06;
  localparam logic [4:0] ADDR_OUTCTL = 5'h0C;
  localparam logic [4:0] ADDR_PHASE = 5'h0D;
  localparam logic [4:0] ADDR_MODE = 5'h0E;
  localparam logic [4:0] ADDR_CLKSEL = 5'h0F;
  localparam logic [4:0] ADDR_STATUS = 5'h10;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int NUM_CH = 6;
  localparam int PHASE_SEL_LSB = 2;
  localparam int PHASE_W45_BIT = 1;
  localparam int PHASE_W23_BIT = 0;
  localparam int MODE_DIV0_BIT = 0;
  localparam int MODE_T12_LSB = 2;
  localparam int MODE_W01_BIT = 5;
  localparam logic [7:0] REG_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Last duty counter value of one cycle per mode
  // ----------------------------------------------------------------
  localparam logic [15:0] LAST_8 = 16'h00FE;
  localparam logic [15:0] LAST_12 = 16'h0FFE;
  localparam logic [15:0] LAST_16 = 16'hFFFE;
  localparam logic [15:0] LAST_DIV = 16'h00FF;
  localparam logic [3:0] SLOT_LAST = 4'hF;

  // ----------------------------------------------------------------
  // Count source selection codes
  // ----------------------------------------------------------------
  localparam logic [1:0] SRC_DIV1 = 2'h0;
  localparam logic [1:0] SRC_DIV2 = 2'h1;
  localparam logic [1:0] SRC_DIV4 = 2'h2;
  localparam logic [1:0] SRC_DIV8 = 2'h3;

  typedef enum logic [1:0] {PWU_W8, PWU_W12, PWU_W16} pwu_width_e;

  typedef struct packed {
    logic [4:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pwu_bus_req_s;

endpackage : pwu_pkg

// file: pwu_top.sv
// Six-channel pulse width unit with 8/12/16-bit single pulse and pulse division modes.
// Assumes one clock, an asynchronous active-low reset and a master that never overlaps strobes.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - 8-bit period is 255 times (n+1)
// - 12-bit uses even prescaler, period 4095(n+1)
// - 16-bit uses even prescaler, period 65535(n+1)
// - Division: basic pulse 16(n+1), conversion 256(n+1)
// - Count source is clock divided 1,2,4,8
// - 8-bit high time is period times m/255
// - 12-bit high time is period times m/4095
// - 12-bit duty uses upper register bits 3:0
// - 16-bit duty cascades two registers
// - Odd channel is upper half of pair
// - Division upper nibble is basic duty sixteenths
// - Division lower nibble counts extra pulses
// - Extra pulse sits just before basic rise
// - Enabled output starts with high level
// - Output high while counter below latched duty
// - Duty counter steps once per PWM clock
// - Clock generator counts down, PWM clock at zero
// - Duty latch loads at duty counter overflow
// - Prescaler latch loads at generator underflow
// - Phase select one inverts the output
module pwu_top (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register port
  input wire pwu_pkg::pwu_bus_req_s bus_req,
  output logic [7:0] bus_rdata,
  // Pulse outputs
  output logic [5:0] pwm_out
);

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  logic [7:0] duty_setting_q [pwu_pkg::NUM_CH];
  logic [7:0] prescaler_setting_q [pwu_pkg::NUM_CH];
  logic [5:0] output_control_register_q;
  logic [7:0] phase_ctl_q;
  logic [7:0] mode_ctl_q;
  logic [1:0] clk_sel_q;
  logic [7:0] rdata_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int c = 0; c < pwu_pkg::NUM_CH; c++) begin
        duty_setting_q[c] <= pwu_pkg::REG_RESET;
        prescaler_setting_q[c] <= pwu_pkg::REG_RESET;
      end
      output_control_register_q <= 6'h00;
      phase_ctl_q <= pwu_pkg::REG_RESET;
      mode_ctl_q <= pwu_pkg::REG_RESET;
      clk_sel_q <= 2'h0;
    end else if (bus_req.wr) begin
      for (int c = 0; c < pwu_pkg::NUM_CH; c++) begin
        if (bus_req.addr == pwu_pkg::ADDR_DUTY0 + 5'(c)) begin
          duty_setting_q[c] <= bus_req.wdata;
        end
        if (bus_req.addr == pwu_pkg::ADDR_PRE0 + 5'(c)) begin
          prescaler_setting_q[c] <= bus_req.wdata;
        end
      end
      if (bus_req.addr == pwu_pkg::ADDR_OUTCTL) begin
        output_control_register_q <= bus_req.wdata[5:0];
      end
      if (bus_req.addr == pwu_pkg::ADDR_PHASE) begin
        phase_ctl_q <= bus_req.wdata;
      end
      if (bus_req.addr == pwu_pkg::ADDR_MODE) begin
        mode_ctl_q <= {2'h0, bus_req.wdata[5:0]};
      end
      if (bus_req.addr == pwu_pkg::ADDR_CLKSEL) begin
        clk_sel_q <= bus_req.wdata[1:0];
      end
    end
  end

  // Read data stands for exactly the cycle after the read strobe.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= 8'h00;
      if (bus_req.rd) begin
        for (int c = 0; c < pwu_pkg::NUM_CH; c++) begin
          if (bus_req.addr == pwu_pkg::ADDR_DUTY0 + 5'(c)) begin
            rdata_q <= duty_setting_q[c];
          end
          if (bus_req.addr == pwu_pkg::ADDR_PRE0 + 5'(c)) begin
            rdata_q <= prescaler_setting_q[c];
          end
        end
        unique case (bus_req.addr)
          pwu_pkg::ADDR_OUTCTL: rdata_q <= {2'h0, output_control_register_q};
          pwu_pkg::ADDR_PHASE: rdata_q <= phase_ctl_q;
          pwu_pkg::ADDR_MODE: rdata_q <= mode_ctl_q;
          pwu_pkg::ADDR_CLKSEL: rdata_q <= {6'h00, clk_sel_q};
          pwu_pkg::ADDR_STATUS: rdata_q <= {2'h0, pwm_out};
          default: ;
        endcase
      end
    end
  end

  assign bus_rdata = rdata_q;

  // ----------------------------------------------------------------
  // Count source divider
  // ----------------------------------------------------------------
  logic [2:0] div_q;
  logic src_tick;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      div_q <= 3'h0;
    end else begin
      div_q <= div_q + 3'h1;
    end
  end

  always_comb begin
    unique case (clk_sel_q)
      pwu_pkg::SRC_DIV1: src_tick = 1'b1;
      pwu_pkg::SRC_DIV2: src_tick = div_q[0];
      pwu_pkg::SRC_DIV4: src_tick = &div_q[1:0];
      pwu_pkg::SRC_DIV8: src_tick = &div_q;
    endcase
  end

  // ----------------------------------------------------------------
  // Pair width decode
  // ----------------------------------------------------------------
  pwu_pkg::pwu_width_e pair_w [3];
  logic [2:0] pair_wide;

  assign pair_wide = {phase_ctl_q[pwu_pkg::PHASE_W45_BIT], phase_ctl_q[pwu_pkg::PHASE_W23_BIT],
                      mode_ctl_q[pwu_pkg::MODE_W01_BIT]};

  always_comb begin
    for (int p = 0; p < 3; p++) begin
      if (pair_wide[p]) begin
        pair_w[p] = pwu_pkg::PWU_W16;
      end else if (mode_ctl_q[pwu_pkg::MODE_T12_LSB + p]) begin
        pair_w[p] = pwu_pkg::PWU_W12;
      end else begin
        pair_w[p] = pwu_pkg::PWU_W8;
      end
    end
  end

  // Rank of each basic pulse in the extra pulse fill order.
  function automatic logic [3:0] fill_rank(input logic [3:0] k);
    logic [3:0] n;
    n = ~k;
    return {n[0], n[1], n[2], n[3]};
  endfunction : fill_rank

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  logic [7:0] cg_q [pwu_pkg::NUM_CH];
  logic [7:0] pre_lat_q [pwu_pkg::NUM_CH];
  logic [15:0] cnt_q [pwu_pkg::NUM_CH];
  logic [15:0] duty_lat_q [pwu_pkg::NUM_CH];
  logic [15:0] last [pwu_pkg::NUM_CH];
  logic out_q [pwu_pkg::NUM_CH];
  logic en [pwu_pkg::NUM_CH];
  logic pwm_clk [pwu_pkg::NUM_CH];
  logic raw [pwu_pkg::NUM_CH];

  for (genvar i = 0; i < pwu_pkg::NUM_CH; i++) begin : g_ch
    localparam int P = i / 2;
    localparam int HI = i | 1;
    localparam bit ODD = (i % 2) == 1;
    logic idle;
    logic div_mode;
    logic [15:0] duty_src;
    logic [3:0] slot;
    logic [3:0] next_k;

    // The odd channel of a wide pair only supplies the upper duty half.
    assign idle = ODD && (pair_w[P] != pwu_pkg::PWU_W8);
    assign div_mode = (i < 2) && mode_ctl_q[pwu_pkg::MODE_DIV0_BIT + i];
    assign en[i] = output_control_register_q[i] && !idle;
    assign pwm_clk[i] = src_tick && (cg_q[i] == 8'h00);
    assign slot = cnt_q[i][3:0];
    assign next_k = cnt_q[i][7:4] + 4'h1;

    always_comb begin
      if (ODD || pair_w[P] == pwu_pkg::PWU_W8) begin
        duty_src = {8'h00, duty_setting_q[i]};
      end else if (pair_w[P] == pwu_pkg::PWU_W12) begin
        duty_src = {4'h0, duty_setting_q[HI][3:0], duty_setting_q[i]};
      end else begin
        duty_src = {duty_setting_q[HI], duty_setting_q[i]};
      end
      if (div_mode) begin
        last[i] = pwu_pkg::LAST_DIV;
      end else if (ODD || pair_w[P] == pwu_pkg::PWU_W8) begin
        last[i] = pwu_pkg::LAST_8;
      end else if (pair_w[P] == pwu_pkg::PWU_W12) begin
        last[i] = pwu_pkg::LAST_12;
      end else begin
        last[i] = pwu_pkg::LAST_16;
      end
      if (div_mode) begin
        raw[i] = (slot < duty_lat_q[i][7:4])
          || (slot == pwu_pkg::SLOT_LAST
              && fill_rank(next_k) < duty_lat_q[i][3:0]);
      end else begin
        raw[i] = cnt_q[i] < duty_lat_q[i];
      end
    end

    // Each channel counts its own prescaler; a wide pair runs on the even one.
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        cg_q[i] <= 8'h00;
        pre_lat_q[i] <= 8'h00;
      end else if (!en[i]) begin
        cg_q[i] <= prescaler_setting_q[i];
        pre_lat_q[i] <= prescaler_setting_q[i];
      end else if (pwm_clk[i]) begin
        cg_q[i] <= prescaler_setting_q[i];
        pre_lat_q[i] <= prescaler_setting_q[i];
      end else if (src_tick) begin
        cg_q[i] <= cg_q[i] - 8'h01;
      end
    end

    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        cnt_q[i] <= 16'h0000;
        duty_lat_q[i] <= 16'h0000;
      end else if (!en[i]) begin
        cnt_q[i] <= 16'h0000;
        duty_lat_q[i] <= duty_src;
      end else if (pwm_clk[i]) begin
        if (cnt_q[i] >= last[i]) begin
          cnt_q[i] <= 16'h0000;
          duty_lat_q[i] <= duty_src;
        end else begin
          cnt_q[i] <= cnt_q[i] + 16'h0001;
        end
      end
    end

    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        out_q[i] <= 1'b0;
      end else begin
        out_q[i] <= en[i] && (raw[i] ^ phase_ctl_q[pwu_pkg::PHASE_SEL_LSB + i]);
      end
    end
  end

  always_comb begin
    for (int c = 0; c < pwu_pkg::NUM_CH; c++) begin
      pwm_out[c] = out_q[c];
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_gen_reload: assert property (
    en[0] && $past(en[0]) && pwm_clk[0] |=> cg_q[0] == $past(prescaler_setting_q[0]))
    else $error("generator counter did not reload at zero");

  a_cnt_step: assert property (
    en[0] && pwm_clk[0] && cnt_q[0] < last[0] |=> en[0] -> cnt_q[0] == $past(cnt_q[0]) + 16'h0001)
    else $error("duty counter did not step on PWM clock");

  a_cnt_hold: assert property (
    en[0] && !pwm_clk[0] |=> cnt_q[0] == $past(cnt_q[0]) || !en[0])
    else $error("duty counter moved without PWM clock");

  a_cnt_wrap: assert property (
    en[0] && pwm_clk[0] && cnt_q[0] == last[0] |=> cnt_q[0] == 16'h0000)
    else $error("duty counter did not wrap at cycle end");

  a_duty_latch_hold: assert property (
    en[0] && !(pwm_clk[0] && cnt_q[0] >= last[0]) |=> $stable(duty_lat_q[0]))
    else $error("duty latch changed outside overflow");

  a_pre_latch_hold: assert property (
    en[0] && !pwm_clk[0] |=> $stable(pre_lat_q[0]))
    else $error("prescaler latch changed outside underflow");

  a_out_disabled: assert property (
    !output_control_register_q[1] |=> !pwm_out[1])
    else $error("disabled output not low");

  a_phase_out: assert property (
    en[2] |=> pwm_out[2] == ($past(raw[2]) ^ $past(phase_ctl_q[pwu_pkg::PHASE_SEL_LSB + 2])))
    else $error("output level does not follow compare and phase");

  a_odd_idle: assert property (
    pair_w[0] != pwu_pkg::PWU_W8 ##1 pair_w[0] != pwu_pkg::PWU_W8 |-> !pwm_out[1])
    else $error("odd channel of wide pair is driving");

  a_odd_idle45: assert property (
    pair_w[2] != pwu_pkg::PWU_W8 ##1 pair_w[2] != pwu_pkg::PWU_W8 |-> !pwm_out[5])
    else $error("odd channel of upper wide pair is driving");

  // Source ticks at divide by eight must stand eight clocks apart.
  a_div8_tick: assert property (
    clk_sel_q == pwu_pkg::SRC_DIV8 && src_tick
      |=> (!src_tick || clk_sel_q != pwu_pkg::SRC_DIV8) [*7])
    else $error("divide by eight source ticked early");

  a_gen_step: assert property (
    en[0] && src_tick && !pwm_clk[0] |=> cg_q[0] == $past(cg_q[0]) - 8'h01)
    else $error("generator counter did not count down");

  a_start_high: assert property (
    $rose(en[0]) && !mode_ctl_q[pwu_pkg::MODE_DIV0_BIT] && duty_lat_q[0] != 16'h0000
      && !phase_ctl_q[pwu_pkg::PHASE_SEL_LSB] |=> pwm_out[0])
    else $error("enabled output did not start high");

  a_duty_latch_load: assert property (
    en[0] && pwm_clk[0] && cnt_q[0] >= last[0]
      |=> duty_lat_q[0][7:0] == $past(duty_setting_q[0]))
    else $error("duty latch did not load at overflow");

  a_pre_latch_load: assert property (
    en[0] && pwm_clk[0] |=> pre_lat_q[0] == $past(prescaler_setting_q[0]))
    else $error("prescaler latch did not load at underflow");

  c_wrap8: cover property (en[0] && pwm_clk[0] && cnt_q[0] == pwu_pkg::LAST_8);
  c_wide16: cover property (en[0] && pair_w[0] == pwu_pkg::PWU_W16 && pwm_out[0]);
  c_div_extra: cover property (en[0] && mode_ctl_q[0] && raw[0] && cnt_q[0][3:0] == 4'hF);
  c_inverted: cover property (en[2] && phase_ctl_q[pwu_pkg::PHASE_SEL_LSB + 2] && pwm_out[2]);
  c_wide12: cover property (en[4] && pair_w[2] == pwu_pkg::PWU_W12 && pwm_out[4]);

endmodule : pwu_top

`default_nettype wire

// file: tb_top.sv
// Self-checking testbench for the six-channel pulse width unit.
// Assumes pwu_pkg and pwu_top are compiled first; the bench drives the register port itself.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk;
  logic reset_n;
  pwu_pkg::pwu_bus_req_s bus_req;
  logic [7:0] bus_rdata;
  logic [5:0] pwm_out;
  int n_errors;
  int n_checks;
  int cyc;
  localparam int LIMIT = 60000;

  pwu_top u_pwu_top (
    .clk(clk),
    .reset_n(reset_n),
    .bus_req(bus_req),
    .bus_rdata(bus_rdata),
    .pwm_out(pwm_out)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic do_reset;
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
  endtask : do_reset

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_req.addr <= a;
    bus_req.wdata <= d;
    bus_req.wr <= 1'b1;
    @(posedge clk);
    bus_req.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge clk);
    bus_req.addr <= a;
    bus_req.rd <= 1'b1;
    @(posedge clk);
    bus_req.rd <= 1'b0;
    @(posedge clk);
    d = bus_rdata;
  endtask : rd

  // Counts cycles while the channel holds one level, up to a ceiling.
  task automatic run(input int ch, input logic lvl, input int max, output int n);
    n = 0;
    while (pwm_out[ch] === lvl && n < max) begin
      n++;
      @(posedge clk);
    end
  endtask : run

  // The first pulse is skipped because it may start part way through a source tick.
  task automatic pulse(input int ch, output int h, output int p);
    int l;
    run(ch, 1'b0, 70000, l);
    run(ch, 1'b1, 70000, h);
    run(ch, 1'b0, 70000, l);
    run(ch, 1'b1, 70000, h);
    run(ch, 1'b0, 70000, l);
    p = h + l;
  endtask : pulse

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    logic [7:0] d;
    do_reset();
    check("outputs", 32'(pwm_out), 32'h0);
    rd(pwu_pkg::ADDR_STATUS, d);
    check("status", 32'(d), 32'h0);
    for (int i = 0; i < 12; i++) begin
      rd(pwu_pkg::ADDR_DUTY0 + 5'(i), d);
      check("reset value", 32'(d), 32'h0);
      wr(pwu_pkg::ADDR_DUTY0 + 5'(i), 8'hA0 + 8'(i));
    end
    for (int i = 0; i < 12; i++) begin
      rd(pwu_pkg::ADDR_DUTY0 + 5'(i), d);
      check("readback", 32'(d), 32'hA0 + 32'(i));
    end
    wr(pwu_pkg::ADDR_MODE, 8'hFF);
    rd(pwu_pkg::ADDR_MODE, d);
    check("mode reserved bits", 32'(d), 32'h3F);
    rd(5'h1F, d);
    check("unmapped read", 32'(d), 32'h0);
    $display("register test done");
  endtask : t_regs

  task automatic t_src;
    int h;
    int p;
    for (int s = 0; s < 4; s++) begin
      do_reset();
      wr(pwu_pkg::ADDR_DUTY0, 8'h03);
      wr(pwu_pkg::ADDR_PRE0, 8'h01);
      wr(pwu_pkg::ADDR_CLKSEL, 8'(s));
      wr(pwu_pkg::ADDR_OUTCTL, 8'h01);
      pulse(0, h, p);
      check("high time", 32'(h), 32'(6 << s));
      check("period", 32'(p), 32'(510 << s));
    end
    $display("source test done");
  endtask : t_src

  task automatic t_phase;
    int h;
    int p;
    do_reset();
    wr(pwu_pkg::ADDR_DUTY0, 8'h03);
    wr(pwu_pkg::ADDR_PHASE, 8'h04);
    wr(pwu_pkg::ADDR_OUTCTL, 8'h01);
    pulse(0, h, p);
    check("inverted high", 32'(h), 32'd252);
    check("inverted period", 32'(p), 32'd255);
    $display("phase test done");
  endtask : t_phase

  task automatic t_latch;
    int h;
    int p;
    do_reset();
    wr(pwu_pkg::ADDR_DUTY0, 8'h03);
    wr(pwu_pkg::ADDR_OUTCTL, 8'h01);
    pulse(0, h, p);
    run(0, 1'b1, 300, h);
    wr(pwu_pkg::ADDR_DUTY0, 8'h0A);
    run(0, 1'b0, 100, p);
    check("low after new duty", 32'(p), 32'd100);
    run(0, 1'b0, 300, p);
    run(0, 1'b1, 300, h);
    check("new duty high", 32'(h), 32'd10);
    $display("latch test done");
  endtask : t_latch

  task automatic t_twelve;
    int h;
    int p;
    int bad;
    do_reset();
    for (int c = 0; c < 6; c += 2) begin
      wr(pwu_pkg::ADDR_DUTY0 + 5'(c), 8'h05);
      wr(pwu_pkg::ADDR_DUTY0 + 5'(c + 1), 8'hF1);
      wr(pwu_pkg::ADDR_PRE0 + 5'(c + 1), 8'h03);
    end
    wr(pwu_pkg::ADDR_MODE, 8'h1C);
    wr(pwu_pkg::ADDR_OUTCTL, 8'h3F);
    pulse(0, h, p);
    check("12-bit high", 32'(h), 32'd261);
    check("12-bit period", 32'(p), 32'd4095);
    bad = 0;
    repeat (4200) begin
      @(posedge clk);
      if (pwm_out !== {1'b0, pwm_out[0], 1'b0, pwm_out[0], 1'b0, pwm_out[0]}) begin
        bad++;
      end
    end
    check("12-bit pairs 23 and 45", 32'(bad), 32'h0);
    $display("twelve bit test done");
  endtask : t_twelve

  task automatic t_sixteen;
    int hi [3];
    int bad;
    int l;
    do_reset();
    for (int c = 0; c < 6; c += 2) begin
      wr(pwu_pkg::ADDR_DUTY0 + 5'(c), 8'h02);
      wr(pwu_pkg::ADDR_DUTY0 + 5'(c + 1), 8'h01);
      wr(pwu_pkg::ADDR_PRE0 + 5'(c + 1), 8'hFF);
    end
    wr(pwu_pkg::ADDR_MODE, 8'h20);
    wr(pwu_pkg::ADDR_PHASE, 8'h03);
    wr(pwu_pkg::ADDR_OUTCTL, 8'h3F);
    hi = '{0, 0, 0};
    bad = 0;
    repeat (400) begin
      @(posedge clk);
      for (int q = 0; q < 3; q++) begin
        if (pwm_out[2 * q] === 1'b1) begin
          hi[q]++;
        end
        if (pwm_out[2 * q + 1] !== 1'b0) begin
          bad++;
        end
      end
    end
    check("16-bit high pair 01", 32'(hi[0]), 32'd258);
    check("16-bit high", 32'(hi[1]), 32'd258);
    check("16-bit high pair 45", 32'(hi[2]), 32'd258);
    check("16-bit odd idle", 32'(bad), 32'h0);
    run(2, 1'b0, 5000, l);
    check("16-bit low stretch", 32'(l), 32'd5000);
    $display("sixteen bit test done");
  endtask : t_sixteen

  task automatic t_div;
    int h;
    int p;
    int sum;
    int bad;
    do_reset();
    wr(pwu_pkg::ADDR_DUTY0, 8'h40);
    wr(pwu_pkg::ADDR_DUTY0 + 5'd1, 8'h40);
    wr(pwu_pkg::ADDR_MODE, 8'h03);
    wr(pwu_pkg::ADDR_OUTCTL, 8'h03);
    pulse(0, h, p);
    check("basic high", 32'(h), 32'd4);
    check("basic period", 32'(p), 32'd16);
    wr(pwu_pkg::ADDR_DUTY0, 8'h4F);
    wr(pwu_pkg::ADDR_DUTY0 + 5'd1, 8'h4F);
    repeat (600) @(posedge clk);
    sum = 0;
    bad = 0;
    for (int i = 0; i < 256; i++) begin
      @(posedge clk);
      if (pwm_out[0] === 1'b1) begin
        sum++;
      end
      if (pwm_out[1] !== pwm_out[0]) begin
        bad++;
      end
    end
    check("conversion high total", 32'(sum), 32'd79);
    check("channel 1 division", 32'(bad), 32'h0);
    $display("division test done");
  endtask : t_div

  // ----------------------------------------------------------------
  // Timeout and main sequence
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_errors++;
      conclude();
    end
  end

  initial begin
    reset_n = 1'b0;
    bus_req = '0;
    n_errors = 0;
    n_checks = 0;
    cyc = 0;
    t_regs();
    t_src();
    t_phase();
    t_latch();
    t_twelve();
    t_sixteen();
    t_div();
    conclude();
  end
endmodule : tb_top
`default_nettype wire
